// File: cursor_regs.sv
/*
 * apb register bank for the lcd hardware cursor: position with sign,
 * two 5/6/5 colours, fifo high threshold, with vblank commit.
 * positions are snapshotted when the high vertical byte is written and
 * reach the display at the next rising edge of the vblank level.
 * assumes a 20 MHz clock and a vblank level from the lcd timing logic,
 * synchronous to that clock and low outside the non-display period;
 * assumes the consumer ignores vertical position unless cursor mode is on.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - position writes stay pending until high vertical byte written, then vblank
// - high vertical byte write itself reaches display at next vblank
// - vertical position is 10 bits: low byte plus high byte bits 1-0
// - vertical position is used only in cursor mode, ignored otherwise
// - colour 0 blue is bits 4-0 of its register
// - colour 0 green is bits 5-0 of its register
// - colour 0 red is bits 4-0 of its register
// - colour 1 blue is bits 4-0 of its register
// - colour 1 green is bits 5-0 of its register
// - colour 1 red is bits 4-0 of its register
// - 4-bit fifo high threshold sets when fetch fifo requests memory
// - threshold zero means hardware picks the threshold itself
// - 2-bit mode: 00 inactive, 01 cursor, 10 ink, 11 reserved
module cursor_regs #(
   parameter logic [3:0] AUTO_THR = cursor_regs_pkg::AUTO_THR_DEFAULT
) (
   input wire logic ref_clk_in, // 20 MHz clock
   input wire logic sys_rst_in, // synchronous reset, active high
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb direction
   input wire logic [11:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   input wire logic vblank_in, // lcd vertical non-display level
   output logic [31:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error on unmapped address
   output logic [1:0] mode_out, // active ink/cursor mode
   output logic cursor_en_out, // cursor mode active
   output logic [9:0] hpos_out, // active horizontal position
   output logic hsign_out, // active horizontal sign
   output logic [9:0] vpos_out, // active vertical position
   output logic vsign_out, // active vertical sign
   output logic [15:0] color0_out, // colour 0 as 5/6/5
   output logic [15:0] color1_out, // colour 1 as 5/6/5
   output logic [3:0] fifo_thr_out // effective fifo high threshold
);
   logic [7:0] hpos_low;
   logic [7:0] hpos_high;
   logic [7:0] vpos_low;
   logic [7:0] vpos_high;
   logic [7:0] c0_b;
   logic [7:0] c0_g;
   logic [7:0] c0_r;
   logic [7:0] c1_b;
   logic [7:0] c1_g;
   logic [7:0] c1_r;
   logic [7:0] fifo_thr;
   logic [1:0] mode;
   logic commit_pending;
   logic vblank_d;
   logic vblank_rise;
   logic wr_en;
   logic rd_en;
   logic [7:0] idx;
   logic idx_ok;
   logic [31:0] next_rdata;
   logic [9:0] staged_hpos;
   logic staged_hsign;
   logic [9:0] staged_vpos;
   logic staged_vsign;
   logic arm_commit;
   logic apply_commit;

   // apb decode; always answers in the access cycle
   assign idx = paddr_in[9:2];
   assign wr_en = psel_in && penable_in && pwrite_in && idx_ok;
   assign rd_en = psel_in && !penable_in && !pwrite_in;
   assign vblank_rise = vblank_in && !vblank_d;

   // commit strobes: arm on the high vertical byte, apply on a vblank rise
   assign arm_commit = wr_en && (idx == cursor_regs_pkg::IDX_VPOS_HIGH);
   assign apply_commit = vblank_rise && commit_pending;

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h0000_00, b};
   endfunction

   // keep only the sign and the two top position bits of a high byte
   function automatic logic [7:0] pos_high_byte(input logic [7:0] b);
      pos_high_byte = {b[cursor_regs_pkg::SIGN_BIT], 5'h00, b[1:0]};
   endfunction

   // pack red, green and blue bytes into one 5/6/5 word
   function automatic logic [15:0] pack_565(input logic [7:0] r, input logic [7:0] g,
      input logic [7:0] b);
      pack_565 = {r[4:0], g[5:0], b[4:0]};
   endfunction

   // join the two top bits of a high byte and a low byte into a position
   function automatic logic [9:0] join_pos(input logic [7:0] hi, input logic [7:0] lo);
      join_pos = {hi[1:0], lo};
   endfunction

   // clear the unused upper bits of a five-bit colour field
   function automatic logic [7:0] field5(input logic [7:0] b);
      field5 = {3'h0, b[4:0]};
   endfunction

   // clear the unused upper bits of a six-bit colour field
   function automatic logic [7:0] field6(input logic [7:0] b);
      field6 = {2'h0, b[5:0]};
   endfunction

   // effective threshold: a zero field hands the choice to the built-in default
   function automatic logic [3:0] pick_thr(input logic [7:0] field);
      pick_thr = (field[3:0] == 4'h0) ? AUTO_THR : field[3:0];
   endfunction

   // address map check and read mux
   always_comb begin
      idx_ok = 1'b1;
      next_rdata = 32'h0000_0000;
      case (idx)
         cursor_regs_pkg::IDX_MODE: next_rdata = {30'h0, mode};
         cursor_regs_pkg::IDX_HPOS_LOW: next_rdata = byte_word(hpos_low);
         cursor_regs_pkg::IDX_HPOS_HIGH: next_rdata = byte_word(hpos_high);
         cursor_regs_pkg::IDX_VPOS_LOW: next_rdata = byte_word(vpos_low);
         cursor_regs_pkg::IDX_VPOS_HIGH: next_rdata = byte_word(vpos_high);
         cursor_regs_pkg::IDX_C0_BLUE: next_rdata = byte_word(c0_b);
         cursor_regs_pkg::IDX_C0_GREEN: next_rdata = byte_word(c0_g);
         cursor_regs_pkg::IDX_C0_RED: next_rdata = byte_word(c0_r);
         cursor_regs_pkg::IDX_C1_BLUE: next_rdata = byte_word(c1_b);
         cursor_regs_pkg::IDX_C1_GREEN: next_rdata = byte_word(c1_g);
         cursor_regs_pkg::IDX_C1_RED: next_rdata = byte_word(c1_r);
         cursor_regs_pkg::IDX_FIFO_THR: next_rdata = byte_word(fifo_thr);
         cursor_regs_pkg::IDX_STATUS: next_rdata = {31'h0, commit_pending};
         default: idx_ok = 1'b0;
      endcase
      if (paddr_in[11:10] != 2'h0) begin
         idx_ok = 1'b0;
         next_rdata = 32'h0000_0000;
      end
   end

   // bus answer registers: ready and error in the access cycle
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !idx_ok;
      end
   end

   // read data captured at the setup edge, held until the next read
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_out <= next_rdata;
      end
   end

   // mode register; the reserved code is stored and read back as written
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         mode <= cursor_regs_pkg::MODE_INACTIVE;
      end else if (wr_en && idx == cursor_regs_pkg::IDX_MODE) begin
         mode <= pwdata_in[1:0];
      end
   end

   // position bytes as software sees them; unused high byte bits read 0
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         hpos_low <= cursor_regs_pkg::RST_BYTE;
         hpos_high <= cursor_regs_pkg::RST_BYTE;
         vpos_low <= cursor_regs_pkg::RST_BYTE;
         vpos_high <= cursor_regs_pkg::RST_BYTE;
      end else if (wr_en) begin
         case (idx)
            cursor_regs_pkg::IDX_HPOS_LOW: hpos_low <= pwdata_in[7:0];
            cursor_regs_pkg::IDX_HPOS_HIGH: hpos_high <= pos_high_byte(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_VPOS_LOW: vpos_low <= pwdata_in[7:0];
            cursor_regs_pkg::IDX_VPOS_HIGH: vpos_high <= pos_high_byte(pwdata_in[7:0]);
            default: ;
         endcase
      end
   end

   // colour bytes; only the 5/6/5 field bits are kept, the rest read 0
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         c0_b <= cursor_regs_pkg::RST_BYTE;
         c0_g <= cursor_regs_pkg::RST_BYTE;
         c0_r <= cursor_regs_pkg::RST_BYTE;
         c1_b <= cursor_regs_pkg::RST_BYTE;
         c1_g <= cursor_regs_pkg::RST_BYTE;
         c1_r <= cursor_regs_pkg::RST_BYTE;
      end else if (wr_en) begin
         case (idx)
            cursor_regs_pkg::IDX_C0_BLUE: c0_b <= field5(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_C0_GREEN: c0_g <= field6(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_C0_RED: c0_r <= field5(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_C1_BLUE: c1_b <= field5(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_C1_GREEN: c1_g <= field6(pwdata_in[7:0]);
            cursor_regs_pkg::IDX_C1_RED: c1_r <= field5(pwdata_in[7:0]);
            default: ;
         endcase
      end
   end

   // fifo high threshold byte; only the low four bits are kept
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         fifo_thr <= cursor_regs_pkg::RST_BYTE;
      end else if (wr_en && idx == cursor_regs_pkg::IDX_FIFO_THR) begin
         fifo_thr <= {4'h0, pwdata_in[3:0]};
      end
   end

   // vblank edge detect; the delayed copy idles low like the pin
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         vblank_d <= 1'b0;
      end else begin
         vblank_d <= vblank_in;
      end
   end

   // commit arming; a new arm beats a commit in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         commit_pending <= 1'b0;
      end else if (arm_commit) begin
         commit_pending <= 1'b1;
      end else if (vblank_rise) begin
         commit_pending <= 1'b0;
      end
   end

   // horizontal snapshot taken at the arm, so later byte writes wait for
   // the next arm instead of leaking to the display early
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         staged_hpos <= 10'h000;
         staged_hsign <= 1'b0;
      end else if (arm_commit) begin
         staged_hpos <= join_pos(hpos_high, hpos_low);
         staged_hsign <= hpos_high[cursor_regs_pkg::SIGN_BIT];
      end
   end

   // vertical snapshot; the high byte comes straight from the arming write
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         staged_vpos <= 10'h000;
         staged_vsign <= 1'b0;
      end else if (arm_commit) begin
         staged_vpos <= join_pos(pwdata_in[7:0], vpos_low);
         staged_vsign <= pwdata_in[cursor_regs_pkg::SIGN_BIT];
      end
   end

   // display-side position, applied only at vblank after a commit
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         hpos_out <= 10'h000;
         hsign_out <= 1'b0;
         vpos_out <= 10'h000;
         vsign_out <= 1'b0;
      end else if (apply_commit) begin
         hpos_out <= staged_hpos;
         hsign_out <= staged_hsign;
         vpos_out <= staged_vpos;
         vsign_out <= staged_vsign;
      end
   end

   // mode outputs; the consumer ignores position unless cursor mode is on
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         mode_out <= cursor_regs_pkg::MODE_INACTIVE;
         cursor_en_out <= 1'b0;
      end else begin
         mode_out <= mode;
         cursor_en_out <= (mode == cursor_regs_pkg::MODE_CURSOR);
      end
   end

   // colour outputs as red, green, blue from the top bit down
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         color0_out <= 16'h0000;
         color1_out <= 16'h0000;
      end else begin
         color0_out <= pack_565(c0_r, c0_g, c0_b);
         color1_out <= pack_565(c1_r, c1_g, c1_b);
      end
   end

   // effective fifo threshold seen by the fetch arbitration
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         fifo_thr_out <= AUTO_THR;
      end else begin
         fifo_thr_out <= pick_thr(fifo_thr);
      end
   end
endmodule

// File: cursor_regs_pkg.sv
/*
 * constants for the lcd cursor position and colour register bank.
 * assumes byte-offset registers reached one per 32-bit apb word.
 */
package cursor_regs_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_HPOS_LOW = 8'h72;
   localparam logic [7:0] IDX_HPOS_HIGH = 8'h73;
   localparam logic [7:0] IDX_VPOS_LOW = 8'h74;
   localparam logic [7:0] IDX_VPOS_HIGH = 8'h75;
   localparam logic [7:0] IDX_C0_BLUE = 8'h76;
   localparam logic [7:0] IDX_C0_GREEN = 8'h77;
   localparam logic [7:0] IDX_C0_RED = 8'h78;
   localparam logic [7:0] IDX_C1_BLUE = 8'h7a;
   localparam logic [7:0] IDX_C1_GREEN = 8'h7b;
   localparam logic [7:0] IDX_C1_RED = 8'h7c;
   localparam logic [7:0] IDX_FIFO_THR = 8'h7e;
   localparam logic [7:0] IDX_MODE = 8'h70;
   localparam logic [7:0] IDX_STATUS = 8'h7f;
   // field layout
   localparam int SIGN_BIT = 7;
   localparam int POS_HI_W = 2;
   localparam int BLUE_W = 5;
   localparam int GREEN_W = 6;
   localparam int RED_W = 5;
   localparam int THR_W = 4;
   localparam int MODE_W = 2;
   // mode encodings
   localparam logic [1:0] MODE_INACTIVE = 2'h0;
   localparam logic [1:0] MODE_CURSOR = 2'h1;
   localparam logic [1:0] MODE_INK = 2'h2;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] AUTO_THR_DEFAULT = 4'h8;
endpackage

// File: cursor_regs_assertions.sv
/* port checker for the cursor register bank.
   assumes one clock domain and binding onto cursor_regs. */
`timescale 1ns/1ps
module cursor_regs_assertions (
   input wire logic ref_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, vblank_in,
   input wire logic [11:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, prdata_out,
   input wire logic pready_out, pslverr_out, cursor_en_out, hsign_out, vsign_out,
   input wire logic [1:0] mode_out, // mode
   input wire logic [9:0] hpos_out, vpos_out,
   input wire logic [15:0] color0_out, color1_out,
   input wire logic [3:0] fifo_thr_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   // completed write
   wire wr = psel_in && penable_in && pready_out && pwrite_in;
   a_ready_next: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   a_ready_once: assert property (pready_out |=> !pready_out) else $error("ready too long");
   a_err_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0000_0000)
      else $error("error read not zero");
   a_mode_cursor: assert property (cursor_en_out == (mode_out == 2'h1))
      else $error("cursor enable mismatch");
   a_pos_vblank: assert property ($changed({vsign_out, vpos_out, hsign_out, hpos_out})
      |-> $past(vblank_in) || $past(vblank_in, 2)) else $error("position moved outside vblank");
   a_blue0_write: assert property (wr && paddr_in == 12'h1d8
      |-> ##2 color0_out[4:0] == $past(pwdata_in[4:0], 2)) else $error("blue 0 wrong");
   a_red1_write: assert property (wr && paddr_in == 12'h1f0
      |-> ##2 color1_out[15:11] == $past(pwdata_in[4:0], 2)) else $error("red 1 wrong");
   a_thr_write: assert property (wr && paddr_in == 12'h1f8 && pwdata_in[3:0] != 4'h0
      |-> ##2 fifo_thr_out == $past(pwdata_in[3:0], 2)) else $error("threshold wrong");
   a_thr_auto: assert property (fifo_thr_out != 4'h0) else $error("threshold zero");
endmodule
bind cursor_regs cursor_regs_assertions chk_u (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in,
   .pwrite_in, .vblank_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .cursor_en_out, .hsign_out, .vsign_out, .mode_out, .hpos_out, .vpos_out, .color0_out,
   .color1_out, .fifo_thr_out);

// File: tb_top.sv
/* self-checking bench for the cursor register bank.
   assumes the default automatic threshold of 8. */
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic vblank_in = 0, er, pready_out, pslverr_out, cursor_en_out, hsign_out, vsign_out;
   logic [11:0] paddr_in = 0;
   logic [31:0] pwdata_in = 0, prdata_out, rd, r, hw;
   logic [1:0] mode_out;
   logic [9:0] hpos_out, vpos_out;
   logic [15:0] color0_out, color1_out;
   logic [3:0] fifo_thr_out;
   logic [7:0] v[6];
   logic [7:0] ids[6] = '{8'h76, 8'h77, 8'h78, 8'h7a, 8'h7b, 8'h7c};
   int fail_count = 0, total_checks = 0, cyc = 0, seed = 32'h79c1, i;
   cursor_regs dut_u (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .vblank_in, .prdata_out, .pready_out, .pslverr_out, .mode_out, .cursor_en_out,
      .hpos_out, .hsign_out, .vpos_out, .vsign_out, .color0_out, .color1_out, .fifo_thr_out);
   // clock and hang guard
   always #25 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         wrap_up;
      end
   end
   task wrap_up;
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer, held until ready
   task apb(input logic [7:0] idx, input logic w, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= {2'b00, idx, 2'b00};
      pwdata_in <= d;
      @(posedge ref_clk_in);
      penable_in <= 1;
      do @(posedge ref_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
   endtask
   task settle;
      repeat (2) @(posedge ref_clk_in);
   endtask
   task vb;
      vblank_in <= 1;
      repeat (4) @(posedge ref_clk_in);
      vblank_in <= 0;
      settle;
   endtask
   function logic [7:0] msk(input logic [7:0] idx);
      case (idx)
         8'h77, 8'h7b: msk = 8'h3f;
         default: msk = 8'h1f;
      endcase
   endfunction
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk_in);
      sys_rst_in <= 0;
      settle;
      chk(fifo_thr_out, 32'h0000_0008);
      for (i = 0; i < 6; i++) begin
         r = $random(seed);
         apb(ids[i], 1, r);
         v[i] = r[7:0] & msk(ids[i]);
         apb(ids[i], 0, 0);
         chk(rd, v[i]);
      end
      chk(color0_out, {v[2][4:0], v[1][5:0], v[0][4:0]});
      chk(color1_out, {v[5][4:0], v[4][5:0], v[3][4:0]});
      r = $random(seed) | 1;
      apb(8'h7e, 1, r);
      settle;
      chk(fifo_thr_out, r[3:0]);
      apb(8'h7e, 1, 0);
      settle;
      chk(fifo_thr_out, 32'h0000_0008);
      for (i = 0; i < 4; i++) begin
         apb(8'h70, 1, i);
         settle;
         chk(mode_out, i);
         chk(cursor_en_out, i == 1);
      end
      r = $random(seed);
      hw = $random(seed);
      apb(8'h74, 1, r);
      apb(8'h72, 1, hw);
      apb(8'h73, 1, hw >> 8);
      vb;
      chk(vpos_out, 0);
      chk({hsign_out, hpos_out}, 0);
      apb(8'h75, 1, 32'h0000_00ff);
      apb(8'h74, 1, ~r);
      apb(8'h75, 0, 0);
      chk(rd, 32'h0000_0083);
      apb(8'h7f, 0, 0);
      chk(rd, 32'h0000_0001);
      settle;
      chk(vpos_out, 0);
      vb;
      chk({vsign_out, vpos_out}, {1'b1, 2'b11, r[7:0]});
      chk({hsign_out, hpos_out}, {hw[15], hw[9:0]});
      apb(8'h7f, 0, 0);
      chk(rd, 32'h0000_0000);
      apb(8'h79, 1, $random(seed));
      chk(er, 1);
      apb(8'h79, 0, 0);
      chk({er, rd}, {1'b1, 32'h0000_0000});
      wrap_up;
   end
endmodule
